// ---- uart_status_pkg.sv ----
// Constants and carrier types for the serial port status and mask block.
package uart_status_pkg;
   localparam logic [9:0] IDX_STATUS = 10'h264;
   localparam logic [9:0] IDX_MASK = 10'h266;
   localparam logic [9:0] IDX_TXD = 10'h268;
   localparam logic [9:0] IDX_RXD = 10'h26A;
   localparam logic [9:0] IDX_PEEK = 10'h26C;
   localparam logic [9:0] IDX_CTRL = 10'h27E;
   localparam logic [15:0] MASK_RESET = 16'h02F8;
   localparam logic [15:0] MASK_WRITABLE = 16'hD7FF;
   localparam logic [15:0] CTRL_WRITABLE = 16'h01FF;
   localparam logic [15:0] STICKY_BITS = 16'hD73A;
   localparam logic [15:0] GRP_RS = 16'h1739;
   localparam logic [15:0] GRP_RX = 16'h8082;
   localparam logic [15:0] GRP_TX = 16'h4044;
   localparam int B_RTHR = 15;
   localparam int B_TTHR = 14;
   localparam int B_OVRIM = 12;
   localparam int B_MATCH = 10;
   localparam int B_BRK = 9;
   localparam int B_ADDR = 8;
   localparam int B_RDR = 7;
   localparam int B_TX_HOLDING_EMPTY = 6;
   localparam int B_FER = 5;
   localparam int B_OER = 4;
   localparam int B_PER = 3;
   localparam int B_TX_ALL_EMPTY = 2;
   localparam int B_RX_IDLE_WITH_DATA = 1;
   localparam int B_IDLE = 0;
   localparam logic [5:0] RX_FIFO_DEPTH = 6'd32;
   localparam logic [5:0] RX_THRESH = 6'd16;
   localparam logic [4:0] TX_FIFO_DEPTH = 5'd16;
   localparam logic [4:0] TX_THRESH = 5'd8;
   localparam logic [5:0] IDLE_BITS = 6'd40;
   typedef struct packed {
      logic [6:0] rsvd;
      logic tx_group_enable;
      logic rx_data_group_enable;
      logic rx_status_group_enable;
      logic two_stop_select;
      logic even_parity_select;
      logic parity_enable;
      logic extended_read_enable;
      logic tx_fifo_en;
      logic rx_fifo_en;
   } ctrl_t;
   typedef struct packed {
      logic [7:0] data;
      logic par_bit;
      logic stop_bit;
      logic break_flag;
      logic match;
      logic addr;
      logic lost;
   } rx_char_t;
   typedef struct packed {
      logic addr;
      logic [7:0] data;
   } tx_byte_t;
endpackage

// ---- uart_status_irq_mask.sv ----
// Status flags, interrupt mask and APB registers of the serial port.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module uart_status_irq_mask
   import uart_status_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_rx_line,
   input wire logic bit_tick,
   input wire logic rx_in_frame,
   input wire logic rx_char_valid,
   input wire rx_char_t rx_char,
   input wire logic rx_head_load,
   input wire rx_char_t rx_head,
   input wire logic [5:0] rx_fifo_count,
   input wire logic [4:0] tx_fifo_count,
   input wire logic tx_shift_busy,
   input wire logic tx_take,
   output ctrl_t ctrl,
   output tx_byte_t tx_byte,
   output logic tx_hold_valid,
   output logic tx_push,
   output logic rx_pop,
   output logic irq,
   output logic rx_dma_req
);
   ctrl_t ctrl_reg;
   logic [15:0] mask_reg;
   logic [15:0] stk_reg;
   logic [15:0] stk_next;
   logic [15:0] set_vec;
   logic [15:0] clr_vec;
   logic [15:0] live;
   logic [15:0] status_word;
   logic [15:0] grp;
   logic [15:0] enabled;
   rx_char_t rxd_reg;
   logic [5:0] rxflags_reg;
   logic rdr_reg;
   tx_byte_t tx_hold_reg;
   logic tx_hold_valid_reg;
   logic tx_push_reg;
   logic rx_pop_reg;
   logic idle_reg;
   logic [5:0] idle_cnt_reg;
   logic [31:0] prdata_reg;
   logic access;
   logic setup;
   logic mapped;
   logic wr_status;
   logic wr_mask;
   logic wr_ctrl;
   logic wr_txd;
   logic rd_rxd;
   logic ld_valid;
   rx_char_t ld_char;
   logic ld_lost;
   logic ld_fer;
   logic ld_per;
   logic imm_ovr;
   logic rx_idle_with_data_hit;
   logic tx_holding_empty;
   logic tx_all_empty;
   logic rs_pending;
   logic [15:0] rxd_word;

   // True when an aligned byte address selects the given register index.
   function automatic logic hit(input logic [11:0] a, input logic [9:0] i);
      return (a[1:0] == 2'b00) && (a[11:2] == i);
   endfunction

   // Parity is wrong when the ones count misses the selected sense.
   function automatic logic par_bad(input rx_char_t c, input logic even);
      return (^{c.data, c.par_bit}) ^ ~even;
   endfunction

   // Bus decode; the slave never waits, so pready is tied high.
   assign access = psel & penable;
   assign setup = psel & ~penable;
   assign mapped = hit(paddr, IDX_STATUS) | hit(paddr, IDX_MASK) |
                   hit(paddr, IDX_TXD) | hit(paddr, IDX_RXD) |
                   hit(paddr, IDX_PEEK) | hit(paddr, IDX_CTRL);
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign wr_status = access & pwrite & hit(paddr, IDX_STATUS);
   assign wr_mask = access & pwrite & hit(paddr, IDX_MASK);
   assign wr_ctrl = access & pwrite & hit(paddr, IDX_CTRL);
   assign wr_txd = access & pwrite & hit(paddr, IDX_TXD);
   assign rd_rxd = access & ~pwrite & hit(paddr, IDX_RXD);

   // Character load path into the data register.
   // FIFO mode waits for head.
   always_comb begin
      if (ctrl_reg.rx_fifo_en) begin
         ld_valid = rx_head_load;
         ld_char = rx_head;
         ld_lost = rx_head.lost;
         imm_ovr = rx_char_valid & rx_char.lost;
      end else begin
         ld_valid = rx_char_valid;
         ld_char = rx_char;
         ld_lost = rdr_reg & ~rd_rxd;
         imm_ovr = rx_char_valid & rdr_reg & ~rd_rxd;
      end
   end

   assign ld_fer = ~ld_char.stop_bit;
   assign ld_per = ctrl_reg.parity_enable &
                   par_bad(ld_char, ctrl_reg.even_parity_select);
   assign rx_idle_with_data_hit = bit_tick & serial_rx_line & rdr_reg &
                      (idle_cnt_reg == IDLE_BITS - 6'd1);

   assign tx_all_empty = ctrl_reg.tx_fifo_en ?
                 (tx_fifo_count == 5'd0) & ~tx_shift_busy :
                 ~tx_hold_valid_reg & ~tx_shift_busy;
   assign tx_holding_empty = ctrl_reg.tx_fifo_en ? (tx_fifo_count < TX_FIFO_DEPTH) :
                 ~tx_hold_valid_reg;

   // Hardware set terms of the sticky flags.
   always_comb begin
      set_vec = 16'h0000;
      set_vec[B_RTHR] = ctrl_reg.rx_fifo_en & (rx_fifo_count >= RX_THRESH);
      set_vec[B_TTHR] = ctrl_reg.tx_fifo_en & (tx_fifo_count < TX_THRESH);
      set_vec[B_OVRIM] = imm_ovr;
      set_vec[B_MATCH] = ld_valid & ld_char.match;
      set_vec[B_BRK] = ld_valid & ld_char.break_flag;
      set_vec[B_ADDR] = ld_valid & ld_char.addr;
      set_vec[B_FER] = ld_valid & ld_fer;
      set_vec[B_OER] = ld_valid & ld_lost;
      set_vec[B_PER] = ld_valid & ld_per;
      set_vec[B_RX_IDLE_WITH_DATA] = rx_idle_with_data_hit;
   end

   // writing zero clears; a set in the same cycle wins.
   assign clr_vec = wr_status ? (~pwdata[15:0] & STICKY_BITS) : 16'h0000;
   always_comb begin
      stk_next = ((stk_reg & ~clr_vec) | set_vec) & STICKY_BITS;
      // forced low while parity is off.
      stk_next[B_PER] = stk_next[B_PER] & ctrl_reg.parity_enable;
   end

   // Sticky status flags.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stk_reg <= 16'h0000;
      end else begin
         stk_reg <= stk_next;
      end
   end

   // Live status bits that follow hardware state.
   always_comb begin
      live = 16'h0000;
      live[B_RDR] = rdr_reg;
      live[B_TX_HOLDING_EMPTY] = tx_holding_empty;
      live[B_TX_ALL_EMPTY] = tx_all_empty;
      live[B_IDLE] = idle_reg;
   end
   assign status_word = stk_reg | live;

   // status, mask and group all needed.
   always_comb begin
      grp = 16'h0000;
      if (ctrl_reg.rx_status_group_enable) begin
         grp = grp | GRP_RS;
      end
      if (ctrl_reg.rx_data_group_enable) begin
         grp = grp | GRP_RX;
      end
      if (ctrl_reg.tx_group_enable) begin
         grp = grp | GRP_TX;
      end
   end
   assign enabled = status_word & mask_reg & grp;
   assign irq = |enabled;
   assign rs_pending = |(enabled & GRP_RS);
   // DMA held off by pending status unless extended read is enabled.
   assign rx_dma_req = rdr_reg &
                       ~(rs_pending & ~ctrl_reg.extended_read_enable);

   // Mask and control registers; reserved positions never store.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= MASK_RESET;
      end else if (wr_mask) begin
         mask_reg <= pwdata[15:0] & MASK_WRITABLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= '0;
      end else if (wr_ctrl) begin
         ctrl_reg <= ctrl_t'(pwdata[15:0] & CTRL_WRITABLE);
      end
   end
   assign ctrl = ctrl_reg;

   // Receive data register and its per-character flags.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_reg <= '0;
         rxflags_reg <= 6'h00;
      end else if (ld_valid) begin
         rxd_reg <= ld_char;
         rxflags_reg <= {ld_fer, ld_lost, ld_per, ld_char.match,
                         ld_char.break_flag, ld_char.addr};
      end
   end

   // Data ready; a load in the same cycle as a read keeps it set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdr_reg <= 1'b0;
      end else if (ld_valid) begin
         rdr_reg <= 1'b1;
      end else if (rd_rxd &&
                   (!ctrl_reg.rx_fifo_en || rx_fifo_count == 6'd0)) begin
         rdr_reg <= 1'b0;
      end
   end

   // Reading the data register advances the receive FIFO.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_pop_reg <= 1'b0;
      end else begin
         rx_pop_reg <= rd_rxd & ctrl_reg.rx_fifo_en;
      end
   end
   assign rx_pop = rx_pop_reg;

   // Transmit holding register; the write wins over a take.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_hold_reg <= '0;
         tx_hold_valid_reg <= 1'b0;
      end else if (wr_txd) begin
         tx_hold_reg <= tx_byte_t'(pwdata[8:0]);
         tx_hold_valid_reg <= ~ctrl_reg.tx_fifo_en;
      end else if (tx_take) begin
         tx_hold_valid_reg <= 1'b0;
      end
   end
   assign tx_byte = tx_hold_reg;
   assign tx_hold_valid = tx_hold_valid_reg;

   // In FIFO mode each write becomes one push pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_push_reg <= 1'b0;
      end else begin
         tx_push_reg <= wr_txd & ctrl_reg.tx_fifo_en;
      end
   end
   assign tx_push = tx_push_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_reg <= 1'b0;
      end else if (rx_in_frame || !serial_rx_line) begin
         idle_reg <= 1'b0;
      end else if (rx_char_valid) begin
         idle_reg <= 1'b1;
      end
   end

   // High bit-time counter; any low level restarts it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_reg <= 6'd0;
      end else if (!serial_rx_line) begin
         idle_cnt_reg <= 6'd0;
      end else if (bit_tick && idle_cnt_reg < IDLE_BITS) begin
         idle_cnt_reg <= idle_cnt_reg + 6'd1;
      end
   end

   assign rxd_word = ctrl_reg.extended_read_enable ?
                     {rdr_reg, tx_holding_empty, rdr_reg ? rxflags_reg : 6'h00,
                      rxd_reg.data} :
                     {8'h00, rxd_reg.data};

   // Read data is captured in the setup phase so it leaves a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup) begin
         if (hit(paddr, IDX_STATUS)) begin
            prdata_reg <= {16'h0000, status_word};
         end else if (hit(paddr, IDX_MASK)) begin
            prdata_reg <= {16'h0000, mask_reg};
         end else if (hit(paddr, IDX_CTRL)) begin
            prdata_reg <= {16'h0000, ctrl_reg};
         end else if (hit(paddr, IDX_TXD)) begin
            prdata_reg <= {23'h000000, tx_hold_reg};
         end else if (hit(paddr, IDX_RXD) || hit(paddr, IDX_PEEK)) begin
            prdata_reg <= {16'h0000, rxd_word};
         end else begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end
   assign prdata = prdata_reg;

   // A data register read with nothing waiting and no load.
   sequence s_rd_last;
      rd_rxd && !ld_valid &&
      (!ctrl_reg.rx_fifo_en || rx_fifo_count == 6'd0);
   endsequence

   AST_TX_HOLDING_EMPTY_DROP: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_txd && !ctrl_reg.tx_fifo_en) |=>
      tx_hold_valid && tx_byte == tx_byte_t'($past(pwdata[8:0])))
      else $error("transmit write did not replace held byte");
   AST_FER: assert property (@(posedge pclk) disable iff (!presetn)
      (ld_valid && !ld_char.stop_bit) |=> stk_reg[B_FER])
      else $error("low stop bit did not flag framing");
   AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
      (stk_reg[B_OER] && !wr_status) |=> stk_reg[B_OER])
      else $error("overrun flag fell without a clear");
   AST_FIFO_DELAY: assert property (@(posedge pclk)
      disable iff (!presetn)
      (ctrl_reg.rx_fifo_en && !stk_reg[B_FER] && !rx_head_load) |=>
      !stk_reg[B_FER])
      else $error("framing flag set before head load");
   AST_OVR_IMM: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_reg.rx_fifo_en && rx_char_valid && rx_char.lost) |=>
      stk_reg[B_OVRIM])
      else $error("immediate overrun not flagged");
   AST_PER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_reg.parity_enable |=> !stk_reg[B_PER])
      else $error("parity flag set with parity off");
   AST_TX_ALL_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
      status_word[B_TX_ALL_EMPTY] |-> !tx_shift_busy && tx_holding_empty)
      else $error("empty reported with data pending");
   AST_RX_IDLE_WITH_DATA: assert property (@(posedge pclk) disable iff (!presetn)
      rx_idle_with_data_hit ##1 (!wr_status || pwdata[B_RX_IDLE_WITH_DATA]) |-> stk_reg[B_RX_IDLE_WITH_DATA])
      else $error("idle with data not flagged");
   AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      rx_in_frame |=> !status_word[B_IDLE])
      else $error("line idle during a frame");
   AST_DMA: assert property (@(posedge pclk) disable iff (!presetn)
      (rs_pending && !ctrl_reg.extended_read_enable) |-> !rx_dma_req)
      else $error("receive DMA not inhibited");
   AST_RTHR: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_reg.rx_fifo_en && rx_fifo_count >= 6'd16) |=> stk_reg[B_RTHR])
      else $error("receive threshold not flagged");
   AST_TTHR: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_reg.tx_fifo_en && tx_fifo_count < 5'd8) |=> stk_reg[B_TTHR])
      else $error("transmit threshold not flagged");
   AST_RD_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd_last |=> !rdr_reg)
      else $error("data ready survived last read");
   AST_GROUP: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_reg.tx_group_enable && mask_reg[B_TX_HOLDING_EMPTY] && tx_holding_empty) |-> irq)
      else $error("enabled condition raised no request");
endmodule

// ---- remote_station.sv ----
// Behavioural far side: receive engine, bit timer and transmit shifter.
`timescale 1ns/1ns
module remote_station
   import uart_status_pkg::*;
(
   input wire logic pclk,
   output logic serial_rx_line,
   output logic bit_tick,
   output logic rx_in_frame,
   output logic rx_char_valid,
   output rx_char_t rx_char,
   output logic tx_take
);
   // The line idles high and the engine stays quiet until a task runs.
   initial begin
      serial_rx_line = 1'b1;
      bit_tick = 1'b0;
      rx_in_frame = 1'b0;
      rx_char_valid = 1'b0;
      rx_char = '0;
      tx_take = 1'b0;
   end
   // first stop sample
   // A short low frame, then one completion pulse with the line back high.
   task automatic send(input logic [7:0] d, input logic par, input logic stp);
      @(posedge pclk);
      serial_rx_line <= 1'b0;
      rx_in_frame <= 1'b1;
      repeat (4) @(posedge pclk);
      serial_rx_line <= 1'b1;
      rx_in_frame <= 1'b0;
      rx_char_valid <= 1'b1;
      rx_char <= {d, par, stp, 4'h0};
      @(posedge pclk);
      rx_char_valid <= 1'b0;
      rx_char <= ~{d, par, stp, 4'h0}; // Stale data is not left showing.
   endtask
   // Bit-time pulses while the line stays high.
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         bit_tick <= 1'b1;
         @(posedge pclk);
         bit_tick <= 1'b0;
      end
   endtask
   // The shifter takes the held byte after a chosen delay.
   task automatic take(input int dly);
      repeat (dly) @(posedge pclk);
      tx_take <= 1'b1;
      @(posedge pclk);
      tx_take <= 1'b0;
   endtask
endmodule

// ---- uart_status_irq_mask_tb.sv ----
// Self-checking bench for the serial port status and mask block.
`timescale 1ns/1ns
module uart_status_irq_mask_tb;
   import uart_status_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, se;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic serial_rx_line, bit_tick, rx_in_frame, rx_char_valid, tx_take;
   rx_char_t rx_char;
   ctrl_t ctrl;
   tx_byte_t tx_byte;
   logic tx_hold_valid, tx_push, rx_pop, irq, rx_dma_req;
   logic [5:0] rx_fifo_count;
   logic [4:0] tx_fifo_count;
   logic tx_shift_busy;
   int err_count = 0;
   int tests_run = 0;
   // Clock at 20 MHz.
   always #25 pclk = ~pclk;
   // FIFO load inputs stay idle; FIFO levels and shifter are bench driven.
   uart_status_irq_mask dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_rx_line(serial_rx_line), .bit_tick(bit_tick),
      .rx_in_frame(rx_in_frame), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .rx_head_load(1'b0), .rx_head('0),
      .rx_fifo_count(rx_fifo_count), .tx_fifo_count(tx_fifo_count),
      .tx_shift_busy(tx_shift_busy),
      .tx_take(tx_take), .ctrl(ctrl), .tx_byte(tx_byte),
      .tx_hold_valid(tx_hold_valid), .tx_push(tx_push), .rx_pop(rx_pop),
      .irq(irq), .rx_dma_req(rx_dma_req));
   remote_station far (.pclk(pclk), .serial_rx_line(serial_rx_line),
      .bit_tick(bit_tick), .rx_in_frame(rx_in_frame),
      .rx_char_valid(rx_char_valid), .rx_char(rx_char), .tx_take(tx_take));
   // Compare and count; case inequality so unknowns never match.
   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer; holds the request until pready is seen high.
   task automatic apb(input logic w, input logic [9:0] idx,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Verdict and end of run.
   task automatic end_sim();
      if (err_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Reset values and an unmapped address.
   task automatic t_reset();
      apb(1'b0, IDX_MASK, 32'h0);
      chk("mask", rd, 32'h0000_02F8);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("status", rd, 32'h0000_0044);
      apb(1'b0, 10'h3FF, 32'h0);
      chk("unmapped", {31'h0, se}, 32'h1);
      apb(1'b1, IDX_MASK, 32'h0000_FFFF);
      apb(1'b0, IDX_MASK, 32'h0);
      chk("mask rsvd", rd, 32'h0000_D7FF);
      apb(1'b1, IDX_MASK, 32'h0000_02F8);
   endtask
   // Framing error: status, grouping, DMA inhibit, extended read, clear.
   task automatic t_frame();
      apb(1'b1, IDX_CTRL, 32'h40);
      far.send(8'hA5, 1'b0, 1'b0);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("fer set", rd, 32'h0000_00E5);
      @(negedge pclk);
      chk("irq rs", {31'h0, irq}, 32'h1);
      chk("dma off", {31'h0, rx_dma_req}, 32'h0);
      apb(1'b1, IDX_CTRL, 32'h44);
      @(negedge pclk);
      chk("dma ext", {31'h0, rx_dma_req}, 32'h1);
      apb(1'b0, IDX_RXD, 32'h0);
      chk("rxd ext", rd, 32'h0000_E0A5);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("fer held", rd, 32'h0000_0065);
      apb(1'b1, IDX_CTRL, 32'h04);
      @(negedge pclk);
      chk("irq gated", {31'h0, irq}, 32'h0);
      apb(1'b1, IDX_STATUS, 32'h0);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("fer clr", rd, 32'h0000_0045);
   endtask
   // Parity off then even parity on the same odd-weight character.
   task automatic t_par();
      apb(1'b1, IDX_CTRL, 32'h00);
      far.send(8'h01, 1'b0, 1'b1);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("par off", rd, 32'h0000_00C5);
      apb(1'b0, IDX_RXD, 32'h0);
      chk("rxd", rd, 32'h0000_0001);
      apb(1'b1, IDX_CTRL, 32'h18);
      far.send(8'h01, 1'b0, 1'b1);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("par on", rd, 32'h0000_00CD);
      apb(1'b1, IDX_STATUS, 32'h0);
   endtask
   // Idle with unread data: the 40th bit time sets the flag, not the 39th.
   task automatic t_idle();
      far.ticks(39);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("rx_idle_with_data 39", rd, 32'h0000_00C5);
      far.ticks(1);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("rx_idle_with_data 40", rd, 32'h0000_00C7);
      apb(1'b1, IDX_CTRL, 32'h80);
      @(negedge pclk);
      chk("irq rx", {31'h0, irq}, 32'h1);
      apb(1'b1, IDX_CTRL, 32'h00);
      @(negedge pclk);
      chk("irq none", {31'h0, irq}, 32'h0);
      apb(1'b0, IDX_RXD, 32'h0);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("rdr clr", rd, 32'h0000_0047);
   endtask
   // Transmit writes: a second write while full replaces the first.
   task automatic t_tx();
      apb(1'b1, IDX_TXD, 32'h13C);
      @(negedge pclk);
      chk("hold", {31'h0, tx_hold_valid}, 32'h1);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("tx busy", rd, 32'h0000_0003);
      apb(1'b1, IDX_TXD, 32'h055);
      @(negedge pclk);
      chk("replace", {23'h0, tx_byte}, 32'h0000_0055);
      far.take(3);
      @(negedge pclk);
      chk("taken", {31'h0, tx_hold_valid}, 32'h0);
      apb(1'b1, IDX_CTRL, 32'h100);
      @(negedge pclk);
      chk("irq tx", {31'h0, irq}, 32'h1);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("tx empty", rd, 32'h0000_0047);
   endtask
   // FIFO levels: thresholds set, then a zero status write clears them once the levels move away.
   task automatic t_fifo();
      apb(1'b1, IDX_CTRL, 32'h03);
      @(posedge pclk);
      rx_fifo_count <= 6'h10;
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("fifo thr", rd, 32'h0000_C047);
      @(posedge pclk);
      rx_fifo_count <= 6'h0F;
      tx_fifo_count <= 5'h10;
      tx_shift_busy <= 1'b1;
      apb(1'b1, IDX_STATUS, 32'h0);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("fifo full", rd, 32'h0000_0001);
   endtask
   // Main sequence after a 16-cycle reset.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      rx_fifo_count = 6'h00;
      tx_fifo_count = 5'h00;
      tx_shift_busy = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_frame();
      t_par();
      t_idle();
      t_tx();
      t_fifo();
      end_sim();
   end
   // The sequence needs well under a thousand cycles; this cuts a hang.
   initial begin
      #500000;
      err_count++;
      end_sim();
   end
endmodule
